// File: design/pvic_pkg.sv
// Package of the prioritized vectored interrupt controller.
// Assumes AXI4-Lite register access with 32-bit data, one aligned word per register.
package pvic_pkg;

   // ----------------------------------------
   // Register map (printed offsets are indices)
   // ----------------------------------------
   localparam logic [7:0] PVIC_IDX_EN_B2   = 8'h2C;
   localparam logic [7:0] PVIC_IDX_EN_B3   = 8'h2D;
   localparam logic [7:0] PVIC_IDX_PEND_B2 = 8'h2E;
   localparam logic [7:0] PVIC_IDX_PEND_B3 = 8'h2F;
   localparam logic [7:0] PVIC_IDX_EN_LO   = 8'h3A;
   localparam logic [7:0] PVIC_IDX_EN_HI   = 8'h3B;
   localparam logic [7:0] PVIC_IDX_PEND_LO = 8'h3C;
   localparam logic [7:0] PVIC_IDX_PEND_HI = 8'h3D;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int          PVIC_MASTER_BIT  = 0;
   localparam int          PVIC_SWTRAP_SLOT = 1;
   localparam int          PVIC_WDOG_SLOT   = 2;
   localparam int          PVIC_EXT0_SLOT   = 3;
   localparam int          PVIC_FIRST_SLOT  = 2;
   localparam logic [31:0] PVIC_EN_RESET    = 32'h0000_0000;
   localparam logic [31:0] PVIC_PEND_RESET  = 32'h0000_0000;
   localparam logic [31:0] PVIC_IMPL_MASK   = 32'h0001_FFFC;

   // ----------------------------------------
   // Vectors and timing
   // ----------------------------------------
   localparam logic [19:0] PVIC_VEC_TOP     = 20'hFFFFC;
   localparam logic [19:0] PVIC_VEC_LOW     = 20'hFFF80;
   localparam int          PVIC_ACCEPT_CYC  = 12;

   localparam logic [1:0]  PVIC_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  PVIC_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0]
   {
      PVIC_ST_IDLE = 2'b01,
      PVIC_ST_SEQ  = 2'b10
   } pvic_state_t;

endpackage : pvic_pkg

// File: design/pvic_ctrl.sv
// Prioritized vectored interrupt controller with an AXI4-Lite register slave.
// Assumes the CPU core pulses take_req at an instruction boundary and pulses
// the return strobes; sources deliver one-cycle request pulses on aclk.
//
// Notes on behaviour
// - Sixteen sources, six external, ten internal.
// - Software and watchdog traps pseudo non-maskable.
// - Vector FFFFC downward by four per slot.
// - Lowest slot number wins among simultaneous requests.
// - No ranking among non-maskable sources themselves; the scan here still picks the software trap (slot one) over the watchdog.
// - Maskable needs master, source enable, pin gate.
// - Request sets its pending latch to one.
// - Latches for slots two to sixteen.
// - Accepted source latch cleared right after acceptance.
// - Reset clears every pending latch.
// - Software clears latches, watchdog latch excepted.
// - Writing one to a latch does nothing.
// - Pending latches readable for polling.
// - Pseudo non-maskable ignore master and enables.
// - No pseudo non-maskable nesting during service.
// - Enable group writable; reads show only bit zero and bits two to sixteen.
// - Acceptance clears the master enable flag.
// - Master flag is bit zero, reset zero.
// - Acceptance sequence takes twelve cycles.
// - Maskable return sets the master flag again.
//
// Chosen here: the AXI4-Lite interface to the registers.
module pvic_ctrl #(
   parameter int ACCEPT_CYC = pvic_pkg::PVIC_ACCEPT_CYC
)(
   input  wire logic        aclk,          // System clock, 40 MHz
   input  wire logic        aresetn,       // Synchronous reset, active low
   input  wire logic [7:0]  awaddr,        // Write address
   input  wire logic        awvalid,       // Write address valid
   output logic             awready,       // Write address ready
   input  wire logic [31:0] wdata,         // Write data
   input  wire logic [3:0]  wstrb,         // Write byte strobes
   input  wire logic        wvalid,        // Write data valid
   output logic             wready,        // Write data ready
   output logic [1:0]       bresp,         // Write response
   output logic             bvalid,        // Write response valid
   input  wire logic        bready,        // Write response ready
   input  wire logic [7:0]  araddr,        // Read address
   input  wire logic        arvalid,       // Read address valid
   output logic             arready,       // Read address ready
   output logic [31:0]      rdata,         // Read data
   output logic [1:0]       rresp,         // Read response
   output logic             rvalid,        // Read data valid
   input  wire logic        rready,        // Read data ready
   input  wire logic [31:0] src_req,       // Source request pulses, bit n = slot n
   input  wire logic        ext0_pin_gate, // Gate for external request zero
   input  wire logic        sw_trap_req,   // Software trap instruction pulse
   input  wire logic        take_req,      // CPU at instruction boundary, may take
   input  wire logic        maskable_ret,  // Maskable return op executed
   input  wire logic        nonmask_ret,   // Non-maskable return op executed
   input  wire logic        disable_op,    // Disable-accept op executed
   input  wire logic        enable_op,     // Enable-accept op executed
   output logic             irq_pending,   // An acceptable request waits
   output logic             accept_busy,   // Acceptance sequence running
   output logic             accept_done,   // Pulse: vector valid, sequence over
   output logic [19:0]      vector_addr,   // Vector of the accepted slot
   output logic [4:0]       accept_slot    // Slot number accepted
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [31:0]         en_r;
   logic [31:0]         pend_r;
   logic                swtrap_r;
   logic                nmi_active_r;
   logic                nmi_saved_r;
   pvic_pkg::pvic_state_t state_r;
   logic [4:0]          cnt_r;
   logic [4:0]          sel_r;
   logic [31:0]         eligible;
   logic [4:0]          sel_nxt;
   logic                any_elig;
   logic                start;
   logic                done;

   // ----------------------------------------
   // Eligibility and priority
   // ----------------------------------------
   generate
      for (genvar g = 0; g < 32; g++)
      begin : g_elig
         if (g == pvic_pkg::PVIC_SWTRAP_SLOT)
         begin : g_sw
            assign eligible[g] = swtrap_r & ~nmi_active_r;
         end
         else if (g == pvic_pkg::PVIC_WDOG_SLOT)
         begin : g_wd
            assign eligible[g] = pend_r[g] & ~nmi_active_r;
         end
         else
         begin : g_mk
            assign eligible[g] = pend_r[g] & en_r[pvic_pkg::PVIC_MASTER_BIT] & en_r[g]
                                 & (ext0_pin_gate | (g != pvic_pkg::PVIC_EXT0_SLOT));
         end
      end
   endgenerate

   // Software and watchdog traps cannot both arrive at once in practice;
   // if they do the scan order simply picks one.
   always_comb
   begin
      sel_nxt = 5'h00;
      any_elig = 1'b0;
      for (int i = 31; i >= 1; i--)
      begin
         if (eligible[i])
         begin
            sel_nxt = i[4:0];
            any_elig = 1'b1;
         end
      end
   end

   assign start = (state_r == pvic_pkg::PVIC_ST_IDLE) & take_req & any_elig;
   assign done  = (state_r == pvic_pkg::PVIC_ST_SEQ) & (cnt_r == 5'h00);

   // ----------------------------------------
   // Acceptance sequencer
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r <= pvic_pkg::PVIC_ST_IDLE;
         cnt_r   <= 5'h00;
         sel_r   <= 5'h00;
      end
      else
      begin
         case (state_r)
            pvic_pkg::PVIC_ST_IDLE:
            begin
               if (start)
               begin
                  state_r <= pvic_pkg::PVIC_ST_SEQ;
                  cnt_r   <= 5'(ACCEPT_CYC - 1);
                  sel_r   <= sel_nxt;
               end
            end
            pvic_pkg::PVIC_ST_SEQ:
            begin
               if (cnt_r == 5'h00)
                  state_r <= pvic_pkg::PVIC_ST_IDLE;
               else
                  cnt_r <= cnt_r - 5'h01;
            end
            default: state_r <= pvic_pkg::PVIC_ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Outputs to the CPU
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_pending <= 1'b0;
         accept_busy <= 1'b0;
         accept_done <= 1'b0;
         vector_addr <= pvic_pkg::PVIC_VEC_TOP;
         accept_slot <= 5'h00;
      end
      else
      begin
         irq_pending <= any_elig;
         accept_busy <= start | ((state_r == pvic_pkg::PVIC_ST_SEQ) & ~done);
         accept_done <= done;
         if (done)
         begin
            vector_addr <= pvic_pkg::PVIC_VEC_TOP - {13'h0000, sel_r, 2'b00};
            accept_slot <= sel_r;
         end
      end
   end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   logic        aw_got_r;
   logic        w_got_r;
   logic [7:0]  aw_idx_r;
   logic [8:0]  wd_r;
   wire logic   wr_go = aw_got_r & w_got_r & ~bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready  <= 1'b0;
         wready   <= 1'b0;
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         aw_idx_r <= 8'h00;
         wd_r     <= 9'h000;
         bvalid   <= 1'b0;
         bresp    <= pvic_pkg::PVIC_RESP_OKAY;
      end
      else
      begin
         awready <= ~aw_got_r & ~awready & awvalid;
         wready  <= ~w_got_r & ~wready & wvalid;
         if (awvalid & awready)
         begin
            aw_got_r <= 1'b1;
            aw_idx_r <= {2'b00, awaddr[7:2]};
         end
         if (wvalid & wready)
         begin
            w_got_r <= 1'b1;
            wd_r    <= {wstrb[0], wdata[7:0]};
         end
         if (wr_go)
         begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid   <= 1'b1;
            bresp    <= (aw_idx_r inside {[pvic_pkg::PVIC_IDX_EN_B2:pvic_pkg::PVIC_IDX_PEND_B3],
                          [pvic_pkg::PVIC_IDX_EN_LO:pvic_pkg::PVIC_IDX_PEND_HI]})
                        ? pvic_pkg::PVIC_RESP_OKAY : pvic_pkg::PVIC_RESP_SLVERR;
         end
         else if (bvalid & bready)
            bvalid <= 1'b0;
      end
   end

   // Bit 8 keeps strobe lane 0: a cleared lane leaves every register as it was,
   // while a full word of ones is still an ordinary write.
   wire logic [7:0] wbyte = wd_r[7:0];

   // ----------------------------------------
   // Enable group and master flag
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         en_r        <= pvic_pkg::PVIC_EN_RESET;
         nmi_active_r <= 1'b0;
         nmi_saved_r  <= 1'b0;
      end
      else
      begin
         if (wr_go && wd_r[8])
         begin
            case (aw_idx_r)
               pvic_pkg::PVIC_IDX_EN_LO: en_r[7:0]   <= wbyte;
               pvic_pkg::PVIC_IDX_EN_HI: en_r[15:8]  <= wbyte;
               pvic_pkg::PVIC_IDX_EN_B2: en_r[23:16] <= wbyte;
               pvic_pkg::PVIC_IDX_EN_B3: en_r[31:24] <= wbyte;
               default: ;
            endcase
         end
         if (disable_op)
            en_r[pvic_pkg::PVIC_MASTER_BIT] <= 1'b0;
         if (enable_op | maskable_ret)
            en_r[pvic_pkg::PVIC_MASTER_BIT] <= 1'b1;
         if (nonmask_ret)
         begin
            nmi_active_r <= 1'b0;
            if (nmi_saved_r)
               en_r[pvic_pkg::PVIC_MASTER_BIT] <= 1'b1;
         end
         if (start)
         begin
            en_r[pvic_pkg::PVIC_MASTER_BIT] <= 1'b0;
            if (sel_nxt == 5'(pvic_pkg::PVIC_SWTRAP_SLOT)
                || sel_nxt == 5'(pvic_pkg::PVIC_WDOG_SLOT))
            begin
               nmi_active_r <= 1'b1;
               nmi_saved_r  <= en_r[pvic_pkg::PVIC_MASTER_BIT];
            end
         end
      end
   end

   // ----------------------------------------
   // Pending latches
   // ----------------------------------------
   logic [31:0] sw_clr;
   always_comb
   begin
      sw_clr = 32'h0000_0000;
      if (wr_go && wd_r[8])
      begin
         case (aw_idx_r)
            pvic_pkg::PVIC_IDX_PEND_LO: sw_clr[7:0]   = ~wbyte;
            pvic_pkg::PVIC_IDX_PEND_HI: sw_clr[15:8]  = ~wbyte;
            pvic_pkg::PVIC_IDX_PEND_B2: sw_clr[23:16] = ~wbyte;
            pvic_pkg::PVIC_IDX_PEND_B3: sw_clr[31:24] = ~wbyte;
            default: ;
         endcase
      end
      sw_clr[pvic_pkg::PVIC_WDOG_SLOT] = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pend_r   <= pvic_pkg::PVIC_PEND_RESET;
         swtrap_r <= 1'b0;
      end
      else
      begin
         // Set wins over clear so a request in the clearing cycle survives
         pend_r <= ((pend_r & ~sw_clr
                     & ~((start ? 32'h0000_0001 : 32'h0000_0000) << sel_nxt))
                    | src_req) & pvic_pkg::PVIC_IMPL_MASK;
         swtrap_r <= sw_trap_req
                     | (swtrap_r & ~(start && sel_nxt == 5'(pvic_pkg::PVIC_SWTRAP_SLOT)));
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   wire logic [7:0]  ar_idx = {2'b00, araddr[7:2]};
   wire logic [31:0] en_vis = en_r & (pvic_pkg::PVIC_IMPL_MASK | 32'h0000_0001);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= pvic_pkg::PVIC_RESP_OKAY;
      end
      else
      begin
         arready <= ~arready & ~rvalid & arvalid;
         if (arvalid & arready)
         begin
            rvalid <= 1'b1;
            rresp  <= pvic_pkg::PVIC_RESP_OKAY;
            case (ar_idx)
               pvic_pkg::PVIC_IDX_EN_LO:   rdata <= {24'h000000, en_vis[7:0]};
               pvic_pkg::PVIC_IDX_EN_HI:   rdata <= {24'h000000, en_vis[15:8]};
               pvic_pkg::PVIC_IDX_EN_B2:   rdata <= {24'h000000, en_vis[23:16]};
               pvic_pkg::PVIC_IDX_EN_B3:   rdata <= {24'h000000, en_vis[31:24]};
               pvic_pkg::PVIC_IDX_PEND_LO: rdata <= {24'h000000, pend_r[7:0]};
               pvic_pkg::PVIC_IDX_PEND_HI: rdata <= {24'h000000, pend_r[15:8]};
               pvic_pkg::PVIC_IDX_PEND_B2: rdata <= {24'h000000, pend_r[23:16]};
               pvic_pkg::PVIC_IDX_PEND_B3: rdata <= {24'h000000, pend_r[31:24]};
               default:
               begin
                  rdata <= 32'h0000_0000;
                  rresp <= pvic_pkg::PVIC_RESP_SLVERR;
               end
            endcase
         end
         else if (rvalid & rready)
            rvalid <= 1'b0;
      end
   end

endmodule : pvic_ctrl

// File: sim/pvic_ctrl_assertions.sv
// Checker for the interrupt controller ports.
// Bound into every pvic_ctrl instance; sees its ports only.
module pvic_ctrl_assertions #(
   parameter int ACCEPT_CYC = pvic_pkg::PVIC_ACCEPT_CYC
)(
   input wire logic        aclk,        // Clock
   input wire logic        aresetn,     // Reset, active low
   input wire logic        arvalid,     // Read address valid
   input wire logic        arready,     // Read address ready
   input wire logic        rvalid,      // Read data valid
   input wire logic [31:0] rdata,       // Read data
   input wire logic [1:0]  rresp,       // Read response
   input wire logic        take_req,    // Boundary offer
   input wire logic        nonmask_ret, // Trap return
   input wire logic        accept_busy, // Sequence runs
   input wire logic        accept_done, // Vector valid
   input wire logic [19:0] vector_addr, // Vector
   input wire logic [4:0]  accept_slot  // Slot
);
   localparam int DONE_DLY = ACCEPT_CYC;
   logic trap_r;

   // ----------------------------------------
   // Trap service tracking
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn || nonmask_ret)
         trap_r <= 1'b0;
      else if (accept_done && accept_slot <= 5'h02)
         trap_r <= 1'b1;
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_accept_len: assert property ($rose(accept_busy) |-> ##DONE_DLY accept_done)
      else $error("acceptance length wrong");
   a_take_cause: assert property ($rose(accept_busy) |-> $past(take_req))
      else $error("acceptance without offer");
   a_done_pulse: assert property (accept_done |=> !accept_done)
      else $error("done longer than a cycle");
   a_vector_map: assert property (accept_done |->
      vector_addr == 20'hFFFFC - {13'h0, accept_slot, 2'b00})
      else $error("vector does not match slot");
   a_slot_range: assert property (accept_done |-> accept_slot inside {[1:16]})
      else $error("slot outside served sources");
   a_no_nest: assert property (accept_done && trap_r |-> accept_slot > 5'h02)
      else $error("trap nested in trap");
   a_read_lat: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_err_data: assert property (rvalid && rresp == pvic_pkg::PVIC_RESP_SLVERR |->
      rdata == 32'h0)
      else $error("error read carries data");

   c_swtrap: cover property (accept_done && accept_slot == 5'h01);
   c_wdog: cover property (accept_done && accept_slot == 5'h02);
   c_slverr: cover property (rvalid && rresp == pvic_pkg::PVIC_RESP_SLVERR);
endmodule : pvic_ctrl_assertions

bind pvic_ctrl pvic_ctrl_assertions #(.ACCEPT_CYC(ACCEPT_CYC)) u_chk (.aclk, .aresetn,
   .arvalid, .arready, .rvalid, .rdata, .rresp, .take_req, .nonmask_ret, .accept_busy,
   .accept_done, .vector_addr, .accept_slot);

// File: sim/pvic_cpu_model.sv
// CPU core model: offers acceptance at boundaries, returns after a delay.
// Assumes the controller's one-cycle accept_done pulse.
module pvic_cpu_model #(
   parameter int RET_DLY = 30
)(
   input  wire logic        aclk,         // Clock
   input  wire logic        aresetn,      // Reset, active low
   input  wire logic        irq_pending,  // Request waits
   input  wire logic        accept_busy,  // Sequence runs
   input  wire logic        accept_done,  // Vector valid
   input  wire logic [19:0] vector_addr,  // Vector
   input  wire logic [4:0]  accept_slot,  // Slot
   output logic             take_req,     // Boundary offer
   output logic             maskable_ret, // Maskable return
   output logic             nonmask_ret,  // Trap return
   output logic [7:0]       done_cnt,     // Acceptances seen
   output logic [4:0]       got_slot,     // Last slot
   output logic [19:0]      got_vec       // Last vector
);
   int wait_r;

   // Offers during service too: refusing a nested trap is the controller's job
   always_ff @(posedge aclk)
   begin
      take_req <= aresetn && irq_pending && !accept_busy && !take_req;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         done_cnt <= 8'h00;
         got_slot <= 5'h00;
         got_vec  <= 20'h00000;
         wait_r   <= 0;
      end
      else if (accept_done)
      begin
         done_cnt <= done_cnt + 8'h01;
         got_slot <= accept_slot;
         got_vec  <= vector_addr;
         wait_r   <= RET_DLY;
      end
      else if (wait_r > 0)
         wait_r <= wait_r - 1;
   end

   always_ff @(posedge aclk)
   begin
      maskable_ret <= aresetn && wait_r == 1 && got_slot > 5'h02;
      nonmask_ret  <= aresetn && wait_r == 1 && got_slot <= 5'h02;
   end
endmodule : pvic_cpu_model

// File: sim/pvic_ctrl_tb_top.sv
// Self-checking bench for the interrupt controller.
// Drives the register bus and sources; a CPU model takes the requests.
module pvic_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int RET_DLY = 30;
   typedef struct {int slot; logic gate; logic ok;} pvic_row_t;
   pvic_row_t   rows [7] = '{'{1, 0, 1}, '{2, 0, 1}, '{3, 0, 0}, '{3, 1, 1}, '{4, 0, 1},
                            '{9, 0, 1}, '{16, 0, 1}};
   logic        aclk, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic        rready = 0, ext0_pin_gate = 0, sw_trap_req = 0, enable_op = 0;
   logic        disable_op = 0, awready, wready, bvalid, arready, rvalid, irq_pending;
   logic        accept_busy, accept_done, take_req, maskable_ret, nonmask_ret;
   logic [7:0]  awaddr = 0, araddr = 0, done_cnt, cnt0;
   logic [31:0] wdata = 0, src_req = 0, rdata;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  bresp, rresp;
   logic [19:0] vector_addr, got_vec;
   logic [4:0]  accept_slot, got_slot;
   int          miscompares = 0, checks = 0;

   pvic_ctrl dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .src_req, .ext0_pin_gate, .sw_trap_req, .take_req, .maskable_ret,
      .nonmask_ret, .disable_op, .enable_op, .irq_pending, .accept_busy, .accept_done,
      .vector_addr, .accept_slot);
   pvic_cpu_model #(.RET_DLY(RET_DLY)) cpu (.aclk, .aresetn, .irq_pending, .accept_busy,
      .accept_done, .vector_addr, .accept_slot, .take_req, .maskable_ret, .nonmask_ret,
      .done_cnt, .got_slot, .got_vec);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim

   // Byte address of the enable (p=0) or pending (p=1) byte holding slot n
   function automatic logic [7:0] ra(input logic p, input int n);
      logic [9:0] a;
      case (n / 8)
         0: a = {p ? pvic_pkg::PVIC_IDX_PEND_LO : pvic_pkg::PVIC_IDX_EN_LO, 2'b00};
         1: a = {p ? pvic_pkg::PVIC_IDX_PEND_HI : pvic_pkg::PVIC_IDX_EN_HI, 2'b00};
         2: a = {p ? pvic_pkg::PVIC_IDX_PEND_B2 : pvic_pkg::PVIC_IDX_EN_B2, 2'b00};
         default: a = {p ? pvic_pkg::PVIC_IDX_PEND_B3 : pvic_pkg::PVIC_IDX_EN_B3, 2'b00};
      endcase
      return a[7:0];
   endfunction : ra

   // Handshakes judged at the rising edge that takes them, before the slave updates
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ha, hw, hb;
      hb = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!hb)
      begin
         @(posedge aclk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         hb = bvalid;
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) bready <= 1'b0;
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ha, hr;
      hr = 1'b0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!hr)
      begin
         @(posedge aclk);
         ha = arvalid && arready;
         hr = rvalid;
         d  = rdata;
         r  = rresp;
         if (ha) arvalid <= 1'b0;
         if (hr) rready <= 1'b0;
      end
   endtask : rd

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(d, {24'h0, e});
   endtask : rchk

   task automatic en_op(input logic v);
      @(posedge aclk);
      enable_op  <= v;
      disable_op <= !v;
      @(posedge aclk);
      enable_op  <= 1'b0;
      disable_op <= 1'b0;
   endtask : en_op

   task automatic req(input logic [31:0] s, input logic sw);
      @(posedge aclk);
      src_req     <= s;
      sw_trap_req <= sw;
      @(posedge aclk);
      src_req     <= '0;
      sw_trap_req <= 1'b0;
   endtask : req

   task automatic wait_acc(input logic ok);
      int k;
      k = 0;
      while (done_cnt === cnt0 && k < 60)
      begin
         @(negedge aclk);
         k++;
      end
      chk({31'h0, done_cnt !== cnt0}, {31'h0, ok});
      cnt0 = done_cnt;
   endtask : wait_acc

   // ----------------------------------------
   // Clock, watchdog, tests
   // ----------------------------------------
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   initial
   begin
      #500us;
      miscompares++;
      end_sim();
   end

   initial
   begin : main
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  b;
      int          n;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(ra(0, 0), 8'h00);
      rchk(ra(1, 0), 8'h00);
      rchk(ra(1, 8), 8'h00);
      cnt0 = done_cnt;
      foreach (rows[i])
      begin
         n = rows[i].slot;
         b = 8'h01 << (n % 8);
         ext0_pin_gate <= rows[i].gate;
         if (n > 2) wr(ra(0, n), b);
         if (n > 2) en_op(1'b1);
         req((n == 1) ? 32'h0 : 32'h1 << n, n == 1);
         wait_acc(rows[i].ok);
         if (rows[i].ok)
         begin
            chk({27'h0, got_slot}, n);
            chk({12'h0, got_vec}, 32'h000FFFFC - 4 * n);
            rchk(ra(1, n), 8'h00);
            if (n > 2) rchk(ra(0, 0), (n < 8) ? b : 8'h00);
         end
         else
         begin
            rchk(ra(1, n), b);
            en_op(1'b0);
            wr(ra(1, n), 8'h00);
            rchk(ra(1, n), 8'h00);
         end
         repeat (RET_DLY + 10) @(posedge aclk);
         if (rows[i].ok && n > 2) rchk(ra(0, 0), ((n < 8) ? b : 8'h00) | 8'h01);
         en_op(1'b0);
         if (n > 2) wr(ra(0, n), 8'h00);
      end
      // Two maskable requests in one cycle
      wr(ra(0, 4), 8'h10);
      wr(ra(0, 9), 8'h02);
      req(32'h0000_0210, 1'b0);
      rchk(ra(1, 4), 8'h10);
      rchk(ra(1, 9), 8'h02);
      wr(ra(1, 4), 8'hFF);
      rchk(ra(1, 4), 8'h10);
      en_op(1'b1);
      wait_acc(1'b1);
      chk({27'h0, got_slot}, 32'd4);
      wait_acc(1'b1);
      chk({27'h0, got_slot}, 32'd9);
      repeat (RET_DLY + 10) @(posedge aclk);
      en_op(1'b1);
      // Watchdog trap again during its own service, entered with the master flag set
      req(32'h0000_0004, 1'b0);
      wait_acc(1'b1);
      req(32'h0000_0004, 1'b0);
      wr(ra(1, 2), 8'h00);
      rchk(ra(1, 2), 8'h04);
      chk({24'h0, done_cnt}, {24'h0, cnt0});
      wait_acc(1'b1);
      chk({27'h0, got_slot}, 32'd2);
      repeat (RET_DLY + 10) @(posedge aclk);
      rchk(ra(0, 0), 8'h11);
      en_op(1'b0);
      // Reserved slot, enable group, unmapped address
      wr(ra(0, 20), 8'h10);
      rchk(ra(0, 20), 8'h00);
      req(32'h0010_0000, 1'b0);
      rchk(ra(1, 20), 8'h00);
      wr(ra(0, 8), 8'h5A);
      rchk(ra(0, 8), 8'h5A);
      rd(8'h00, d, r);
      chk({30'h0, r}, {30'h0, pvic_pkg::PVIC_RESP_SLVERR});
      chk(d, 32'h0);
      // Reset in mid-run with a latch and enables set
      req(32'h0000_0100, 1'b0);
      rchk(ra(1, 8), 8'h01);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(ra(1, 8), 8'h00);
      rchk(ra(0, 8), 8'h00);
      end_sim();
   end
endmodule : pvic_ctrl_tb_top
